/* File: rtl/urmz_pkg.sv */
// urmz_pkg: constants for the channel register map and mode register zero.
// assumes one 100 MHz clock shared by the host bus and the channel logic.
package urmz_pkg;
    // register addresses on a[3:0]
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h1;
    localparam logic [3:0] ADDR_CMD = 4'h2;
    localparam logic [3:0] ADDR_FIFO = 4'h3;
    localparam logic [3:0] ADDR_CHG = 4'h4;
    localparam logic [3:0] ADDR_CAUSE = 4'h5;
    localparam logic [3:0] ADDR_CTHI = 4'h6;
    localparam logic [3:0] ADDR_CTLO = 4'h7;
    localparam logic [3:0] ADDR_VEC = 4'hc;
    localparam logic [3:0] ADDR_PINS = 4'hd;
    localparam logic [3:0] ADDR_START = 4'he;
    localparam logic [3:0] ADDR_STOP = 4'hf;
    // mode register zero fields, the mode one rx level bit and reset values
    localparam int MR0_WDOG = 7;
    localparam int MR0_RXLV = 6;
    localparam int MR0_TXLV_HI = 5;
    localparam int MR0_TXLV_LO = 4;
    localparam int MR0_DEEP = 3;
    localparam int MR0_EXT2 = 2;
    localparam int MR0_EXT1 = 0;
    localparam int MR1_RXLV = 6;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // mode register pointer values
    localparam logic [1:0] PTR_MR0 = 2'h0;
    localparam logic [1:0] PTR_MR1 = 2'h1;
    localparam logic [1:0] PTR_MR2 = 2'h2;
    localparam logic [1:0] PTR_STEP = 2'h1;
    // command codes in bits 7:4 of the command byte
    localparam logic [3:0] CMD_PTR_ONE = 4'h1;
    localparam logic [3:0] CMD_PTR_ZERO = 4'hb;
    localparam logic [3:0] CMD_ERR_RST = 4'h4;
    // fifo depths and fill levels
    localparam logic [4:0] DEPTH_SMALL = 5'h08;
    localparam logic [4:0] DEPTH_LARGE = 5'h10;
    localparam logic [4:0] RX_LV_SMALL [4] = '{5'h01, 5'h06, 5'h04, 5'h08};
    localparam logic [4:0] RX_LV_LARGE [4] = '{5'h01, 5'h08, 5'h0c, 5'h10};
    localparam logic [4:0] TX_LV_SMALL [4] = '{5'h08, 5'h04, 5'h06, 5'h01};
    localparam logic [4:0] TX_LV_LARGE [4] = '{5'h10, 5'h08, 5'h0c, 5'h01};
    localparam logic [3:0] PTR_ONE = 4'h1;
    localparam logic [4:0] CNT_ONE = 5'h01;
    // watchdog span in receiver 1x bit periods
    localparam logic [6:0] WD_BITS = 7'h40;
    localparam logic [6:0] WD_LAST = WD_BITS - 7'h01;
    // status and cause bit positions
    localparam int SR_OVR = 4;
    localparam int SR_TXEMT = 3;
    localparam int SR_TXRDY = 2;
    localparam int SR_RXFULL = 1;
    localparam int SR_RXRDY = 0;
    localparam int ISR_CHG = 7;
    localparam int ISR_CTR = 3;
    localparam int ISR_RX = 1;
    localparam int ISR_TX = 0;
endpackage : urmz_pkg

/* File: rtl/urmz_regmap.sv */
// urmz_regmap: host register map, mode pointer, fifos and rx watchdog.
// assumes the host bus strobes run on sys_clk; ip_pins are asynchronous.
`timescale 1ns/10ps
module urmz_regmap (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_bit_tick,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_take,
    input wire logic [6:0] ip_pins,
    input wire logic [15:0] timer_value,
    input wire logic timer_ready,
    output logic rx_request,
    output logic tx_request,
    output logic [7:0] mode_zero,
    output logic [7:0] mode_one,
    output logic [7:0] mode_two,
    output logic [7:0] clock_select,
    output logic [7:0] aux_ctrl,
    output logic [7:0] irq_mask,
    output logic [15:0] timer_preload,
    output logic [7:0] out_config,
    output logic [7:0] out_port,
    output logic [7:0] vector,
    output logic baud_ext1,
    output logic baud_ext2,
    output logic fifo_deep,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic timer_start,
    output logic timer_stop
);
    import urmz_pkg::*;

    typedef struct packed {
        logic [7:0] mr0;
        logic [7:0] mr1;
        logic [7:0] mr2;
        logic [1:0] ptr;
        logic [7:0] baud_clock_select;
        logic [7:0] aux_control;
        logic [7:0] interrupt_enable_mask;
        logic [15:0] ctp;
        logic [7:0] output_pin_function;
        logic [7:0] opr;
        logic [7:0] ivr;
        logic [15:0][7:0] rx_mem;
        logic [3:0] rx_head;
        logic [3:0] rx_tail;
        logic [4:0] rx_count;
        logic [15:0][7:0] tx_mem;
        logic [3:0] tx_head;
        logic [3:0] tx_tail;
        logic [4:0] tx_count;
        logic [6:0] wd_count;
        logic wd_fired;
        logic overrun;
        logic rd_prev;
        logic wr_prev;
        logic [7:0] rd_data;
        logic cmd_strobe;
        logic [7:0] cmd_code;
        logic tm_start;
        logic tm_stop;
        logic [6:0] ip_s0;
        logic [6:0] ip_s1;
        logic [6:0] ip_s2;
        logic [6:0] ip_lvl;
        logic [3:0] ip_delta;
    } urmz_state_type;

    urmz_state_type s;
    urmz_state_type n;

    logic rd_act;
    logic wr_act;
    logic rd_go;
    logic wr_go;
    logic [4:0] limit;
    logic [1:0] rx_code;
    logic [1:0] tx_code;
    logic rx_pop;
    logic rx_push;
    logic tx_push;
    logic tx_pop;
    logic [7:0] rd_val;
    logic [4:0] tx_free;

    // rx fill threshold for a code and depth
    function automatic logic [4:0] rx_level(input logic [1:0] code,
                                            input logic deep);
        rx_level = deep ? RX_LV_LARGE[code] : RX_LV_SMALL[code];
    endfunction
    // tx empty-slot threshold for a code and depth
    function automatic logic [4:0] tx_level(input logic [1:0] code,
                                            input logic deep);
        tx_level = deep ? TX_LV_LARGE[code] : TX_LV_SMALL[code];
    endfunction
    // next mode pointer after one mode access
    function automatic logic [1:0] ptr_after(input logic [1:0] p);
        ptr_after = (p == PTR_MR2) ? PTR_MR2 : p + PTR_STEP;
    endfunction
    // an access is taken once, on the cycle its strobe first goes low
    assign rd_act = !cs_n && !rd_n;
    assign wr_act = !cs_n && !wr_n;
    assign rd_go = rd_act && !s.rd_prev;
    assign wr_go = wr_act && !s.wr_prev;

    // both queues share one depth select
    assign limit = s.mr0[MR0_DEEP] ? DEPTH_LARGE : DEPTH_SMALL;
    assign rx_code = {s.mr0[MR0_RXLV], s.mr1[MR1_RXLV]};
    assign tx_code = {s.mr0[MR0_TXLV_HI], s.mr0[MR0_TXLV_LO]};

    // queue moves; a pop and push in one cycle keep a full rx queue full
    assign rx_pop = rd_go && addr == ADDR_FIFO && s.rx_count != 5'h00;
    assign rx_push = rx_valid && (s.rx_count < limit || rx_pop);
    assign tx_push = wr_go && addr == ADDR_FIFO && s.tx_count < limit;
    assign tx_pop = tx_take && s.tx_count != 5'h00;
    assign tx_free = (s.tx_count < limit) ? limit - s.tx_count : 5'h00;

    // read side of each address; write-only slots read as zero
    always_comb begin
        rd_val = REG_RESET;
        case (addr)
            ADDR_MODE: begin
                case (s.ptr)
                    PTR_MR0: rd_val = s.mr0;
                    PTR_MR1: rd_val = s.mr1;
                    default: rd_val = s.mr2;
                endcase
            end
            ADDR_STAT: begin
                rd_val[SR_OVR] = s.overrun;
                rd_val[SR_TXEMT] = s.tx_count == 5'h00;
                rd_val[SR_TXRDY] = s.tx_count < limit;
                rd_val[SR_RXFULL] = s.rx_count >= limit;
                rd_val[SR_RXRDY] = s.rx_count != 5'h00;
            end
            ADDR_FIFO: rd_val = s.rx_mem[s.rx_head];
            ADDR_CHG: rd_val = {s.ip_delta, s.ip_lvl[3:0]};
            ADDR_CAUSE: begin
                rd_val[ISR_CHG] = |s.ip_delta;
                rd_val[ISR_CTR] = timer_ready;
                rd_val[ISR_RX] = rx_request;
                rd_val[ISR_TX] = tx_request;
            end
            ADDR_CTHI: rd_val = timer_value[15:8];
            ADDR_CTLO: rd_val = timer_value[7:0];
            ADDR_VEC: rd_val = s.ivr;
            ADDR_PINS: rd_val = {1'b0, s.ip_lvl};
            default: rd_val = REG_RESET;
        endcase
    end

    // next state of the whole block
    always_comb begin
        n = s;
        n.rd_prev = rd_act;
        n.wr_prev = wr_act;
        n.cmd_strobe = 1'b0;
        n.tm_start = 1'b0;
        n.tm_stop = 1'b0;
        // pin synchroniser: a change counts once stages two and three agree
        n.ip_s0 = ip_pins;
        n.ip_s1 = s.ip_s0;
        n.ip_s2 = s.ip_s1;
        if (s.ip_s1 == s.ip_s2) begin
            n.ip_lvl = s.ip_s2;
        end
        // host read
        if (rd_go) begin
            n.rd_data = rd_val;
            case (addr)
                ADDR_MODE: n.ptr = ptr_after(s.ptr);
                ADDR_CHG: n.ip_delta = 4'h0;
                ADDR_START: n.tm_start = 1'b1;
                ADDR_STOP: n.tm_stop = 1'b1;
                default: n.ip_delta = n.ip_delta;
            endcase
        end
        // a pin change in the read cycle still sets its delta
        for (int i = 0; i < 4; i++) begin
            if (n.ip_lvl[i] != s.ip_lvl[i]) begin
                n.ip_delta[i] = 1'b1;
            end
        end
        // host write; read-only slots ignore it
        if (wr_go) begin
            case (addr)
                ADDR_MODE: begin
                    case (s.ptr)
                        PTR_MR0: n.mr0 = data_in;
                        PTR_MR1: n.mr1 = data_in;
                        default: n.mr2 = data_in;
                    endcase
                    n.ptr = ptr_after(s.ptr);
                end
                ADDR_STAT: n.baud_clock_select = data_in;
                ADDR_CMD: begin
                    n.cmd_strobe = 1'b1;
                    n.cmd_code = data_in;
                    case (data_in[7:4])
                        CMD_PTR_ZERO: n.ptr = PTR_MR0;
                        CMD_PTR_ONE: n.ptr = PTR_MR1;
                        CMD_ERR_RST: n.overrun = 1'b0;
                        default: n.ptr = s.ptr;
                    endcase
                end
                ADDR_CHG: n.aux_control = data_in;
                ADDR_CAUSE: n.interrupt_enable_mask = data_in;
                ADDR_CTHI: n.ctp[15:8] = data_in;
                ADDR_CTLO: n.ctp[7:0] = data_in;
                ADDR_VEC: n.ivr = data_in;
                ADDR_PINS: n.output_pin_function = data_in;
                ADDR_START: n.opr = s.opr | data_in;
                ADDR_STOP: n.opr = s.opr & ~data_in;
                default: n.opr = s.opr;
            endcase
        end
        // receive queue
        if (rx_pop) begin
            n.rx_head = s.rx_head + PTR_ONE;
        end
        if (rx_push) begin
            n.rx_mem[s.rx_tail] = rx_data;
            n.rx_tail = s.rx_tail + PTR_ONE;
        end else if (rx_valid) begin
            n.overrun = 1'b1; // arrival beats an error reset
        end
        if (rx_push && !rx_pop) begin
            n.rx_count = s.rx_count + CNT_ONE;
        end else if (rx_pop && !rx_push) begin
            n.rx_count = s.rx_count - CNT_ONE;
        end
        // transmit queue
        if (tx_push) begin
            n.tx_mem[s.tx_tail] = data_in;
            n.tx_tail = s.tx_tail + PTR_ONE;
        end
        if (tx_pop) begin
            n.tx_head = s.tx_head + PTR_ONE;
        end
        if (tx_push && !tx_pop) begin
            n.tx_count = s.tx_count + CNT_ONE;
        end else if (tx_pop && !tx_push) begin
            n.tx_count = s.tx_count - CNT_ONE;
        end
        // watchdog restarts on any rx queue access; idle empty queue is quiet
        if (!s.mr0[MR0_WDOG] || s.rx_count == 5'h00 || rx_pop || rx_push)
        begin
            n.wd_count = 7'h00;
            n.wd_fired = 1'b0;
        end else if (rx_bit_tick && !s.wd_fired) begin
            if (s.wd_count == WD_LAST) begin
                n.wd_fired = 1'b1;
            end else begin
                n.wd_count = s.wd_count + 7'h01;
            end
        end
    end

    // state register; pointer comes up at mode one for old software
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.ptr <= PTR_MR1;
            s.mr0 <= MODE_RESET;
            s.mr1 <= MODE_RESET;
            s.mr2 <= MODE_RESET;
        end else begin
            s <= n;
        end
    end

    // level requests; the watchdog only adds to the rx request
    assign rx_request = s.rx_count >= rx_level(rx_code, s.mr0[MR0_DEEP])
                        || s.wd_fired;
    assign tx_request = tx_free >= tx_level(tx_code, s.mr0[MR0_DEEP]);

    // outputs
    assign data_out = s.rd_data;
    assign data_oe = rd_act;
    assign tx_data = s.tx_mem[s.tx_head];
    assign tx_valid = s.tx_count != 5'h00;
    assign mode_zero = s.mr0;
    assign mode_one = s.mr1;
    assign mode_two = s.mr2;
    assign clock_select = s.baud_clock_select;
    assign aux_ctrl = s.aux_control;
    assign irq_mask = s.interrupt_enable_mask;
    assign timer_preload = s.ctp;
    assign out_config = s.output_pin_function;
    assign out_port = s.opr;
    assign vector = s.ivr;
    assign baud_ext1 = s.mr0[MR0_EXT1];
    assign baud_ext2 = s.mr0[MR0_EXT2];
    assign fifo_deep = s.mr0[MR0_DEEP];
    assign cmd_strobe = s.cmd_strobe;
    assign cmd_code = s.cmd_code;
    assign timer_start = s.tm_start;
    assign timer_stop = s.tm_stop;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_ptr_zero_cmd: assert property (
        wr_go && addr == ADDR_CMD && data_in[7:4] == CMD_PTR_ZERO
        |=> s.ptr == PTR_MR0 && mode_zero == $past(s.mr0))
        else $error("pointer not set to mode zero");
    chk_mr0_write: assert property (
        wr_go && addr == ADDR_MODE && s.ptr == PTR_MR0
        |=> mode_zero == $past(data_in) && s.ptr == PTR_MR1)
        else $error("mode zero write lost");
    chk_ptr_stop_two: assert property (
        (rd_go || wr_go) && addr == ADDR_MODE && s.ptr == PTR_MR2
        |=> s.ptr == PTR_MR2)
        else $error("pointer left mode two");
    chk_ptr_legal: assert property (
        s.ptr != 2'h3)
        else $error("pointer out of range");
    chk_wd_fire: assert property (
        $rose(s.wd_fired) |-> $past(s.wd_count) == WD_LAST
        && $past(s.mr0[MR0_WDOG]) && $past(rx_bit_tick))
        else $error("watchdog fired early");
    chk_wd_disabled: assert property (
        !s.mr0[MR0_WDOG] |=> !s.wd_fired)
        else $error("watchdog active while disabled");
    chk_rx_six: assert property (
        !s.mr0[MR0_DEEP] && rx_code == 2'h1 && !s.wd_fired
        |-> rx_request == (s.rx_count >= 5'h06))
        else $error("rx level six wrong");
    chk_rx_twelve: assert property (
        s.mr0[MR0_DEEP] && rx_code == 2'h2 && !s.wd_fired
        |-> rx_request == (s.rx_count >= 5'h0c))
        else $error("rx level twelve wrong");
    chk_tx_depth: assert property (
        !s.mr0[MR0_DEEP] && s.tx_count == 5'h08 && !tx_take
        ##1 !tx_take |-> s.tx_count == 5'h08)
        else $error("tx queue passed eight");
    chk_cmd_read: assert property (
        rd_go && addr == ADDR_CMD |=> data_out == 8'h00 ##1 !timer_start)
        else $error("write-only slot read back");

endmodule : urmz_regmap

/* File: tb/urmz_host.sv */
// urmz_host: behavioural host processor on the parallel register bus.
// assumes sys_clk is shared with the device; calls start 1 ns after an edge.
`timescale 1ns/10ps
module urmz_host
    import urmz_pkg::*;
(
    input wire logic sys_clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out
);
    // bus idles with strobes high and a changing data pattern
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        data_in = 8'h5a;
    end

    // one write, then strobes stay high a full cycle before the next
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        @(posedge sys_clk);
        #1;
        cs_n = 1'b1;
        wr_n = 1'b1;
        data_in = ~d; // released bus must not look like the last byte
        @(posedge sys_clk);
        #1;
    endtask

    // one read; the registered answer is taken once it has landed
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        d = data_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask

    // aim the pointer with a command, then write the mode register
    task automatic set_mode(input logic which, input logic [7:0] v);
        wr(ADDR_CMD, {which ? CMD_PTR_ONE : CMD_PTR_ZERO, 4'h0});
        wr(ADDR_MODE, which ? v : (v & 8'hfd));
    endtask
endmodule // urmz_host

/* File: tb/test_uart_register_map_mode_zero.sv */
// test_uart_register_map_mode_zero: self-checking bench for urmz_regmap.
// assumes urmz_host as bus master; receive side driven by this bench.
`timescale 1ns/10ps
module test_uart_register_map_mode_zero;
    import urmz_pkg::*;
    typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;}
        urmz_row_type;
    logic sys_clk, reset_n, cs_n, rd_n, wr_n, rx_valid, rx_bit_tick;
    logic [3:0] addr;
    logic [7:0] data_in, data_out, rx_data, mode_zero, mode_one, mode_two;
    logic [7:0] clock_select, aux_ctrl, irq_mask, out_config, out_port;
    logic [7:0] vector, rd_val;
    logic [15:0] timer_value, timer_preload;
    logic rx_request, baud_ext1, baud_ext2, fifo_deep;
    logic tx_take, tx_valid, tx_request, data_oe;
    logic cmd_strobe, timer_start, timer_stop;
    logic [7:0] tx_data, cmd_code, last_cmd;
    int fails, n_tests, lvl, k;
    int n_cmd = 0, n_start = 0, n_stop = 0, n_oe = 0;
    // fill thresholds per code, 8-deep then 16-deep
    int lv8 [4] = '{1, 6, 4, 8};
    int lv16 [4] = '{1, 8, 12, 16};
    urmz_row_type rows [9] = '{
        '{4'h1, 8'ha5, 8'ha5}, '{4'h4, 8'h3c, 8'h3c}, '{4'h5, 8'h81, 8'h81},
        '{4'h6, 8'h12, 8'h12}, '{4'h7, 8'h34, 8'h34}, '{4'hd, 8'h5a, 8'h5a},
        '{4'hc, 8'hc3, 8'hc3}, '{4'he, 8'hf0, 8'hf0}, '{4'hf, 8'h30, 8'hc0}};

    urmz_regmap u_urmz_regmap (.sys_clk(sys_clk), .reset_n(reset_n),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_bit_tick(rx_bit_tick),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_take(tx_take),
        .ip_pins(7'h00), .timer_value(timer_value), .timer_ready(1'b0),
        .rx_request(rx_request), .tx_request(tx_request),
        .mode_zero(mode_zero),
        .mode_one(mode_one), .mode_two(mode_two),
        .clock_select(clock_select), .aux_ctrl(aux_ctrl),
        .irq_mask(irq_mask), .timer_preload(timer_preload),
        .out_config(out_config), .out_port(out_port), .vector(vector),
        .baud_ext1(baud_ext1), .baud_ext2(baud_ext2), .fifo_deep(fifo_deep),
        .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .timer_start(timer_start), .timer_stop(timer_stop));

    urmz_host u_urmz_host (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d of %0d checks", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // output that a write to each address should have set
    function automatic logic [7:0] reg_of(input logic [3:0] a);
        case (a)
            4'h1: reg_of = clock_select;
            4'h4: reg_of = aux_ctrl;
            4'h5: reg_of = irq_mask;
            4'h6: reg_of = timer_preload[15:8];
            4'h7: reg_of = timer_preload[7:0];
            4'hd: reg_of = out_config;
            4'hc: reg_of = vector;
            default: reg_of = out_port;
        endcase
    endfunction

    // one received character; an extra cycle lets the request settle
    task automatic push(input logic [7:0] d);
        rx_data = d;
        rx_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        rx_valid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            rx_bit_tick = 1'b1;
            @(posedge sys_clk);
            #1;
            rx_bit_tick = 1'b0;
            @(posedge sys_clk);
            #1;
        end
    endtask

    // one-cycle strobes and data_oe are counted at each edge that samples them
    always @(posedge sys_clk) begin
        if (cmd_strobe) begin
            n_cmd <= n_cmd + 1;
            last_cmd <= cmd_code;
        end
        if (timer_start) begin
            n_start <= n_start + 1;
        end
        if (timer_stop) begin
            n_stop <= n_stop + 1;
        end
        if (data_oe) begin
            n_oe <= n_oe + 1;
        end
    end

    // hang guard, far beyond the roughly eight hundred cycles the run needs
    initial begin
        #300000;
        fails++;
        close_out();
    end

    initial begin
        fails = 0;
        n_tests = 0;
        reset_n = 1'b0;
        rx_valid = 1'b0;
        rx_bit_tick = 1'b0;
        rx_data = 8'h00;
        tx_take = 1'b0;
        timer_value = 16'hbe7d;
        repeat (2) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        // pointer starts at one, walks to two and sticks there
        u_urmz_host.wr(ADDR_MODE, 8'h11);
        chk(mode_one, 8'h11);
        chk(mode_zero, 8'h00);
        u_urmz_host.wr(ADDR_MODE, 8'h22);
        chk(mode_two, 8'h22);
        u_urmz_host.wr(ADDR_MODE, 8'h33);
        chk(mode_two, 8'h33);
        chk(mode_one, 8'h11);
        u_urmz_host.set_mode(1'b0, 8'h44);
        chk(mode_zero, 8'h44);
        u_urmz_host.rd(ADDR_MODE, rd_val);
        chk(rd_val, 8'h11);
        u_urmz_host.rd(ADDR_MODE, rd_val);
        chk(rd_val, 8'h33);
        // baud group and depth bits
        u_urmz_host.set_mode(1'b0, 8'h0d);
        chk(8'(fifo_deep), 8'h01);
        chk({6'h00, baud_ext2, baud_ext1}, 8'h03);
        u_urmz_host.set_mode(1'b0, 8'h04);
        chk(8'(fifo_deep), 8'h00);
        chk({6'h00, baud_ext2, baud_ext1}, 8'h02);
        // write-only registers and the vector land in their outputs
        foreach (rows[i]) begin
            u_urmz_host.wr(rows[i].a, rows[i].d);
            chk(reg_of(rows[i].a), rows[i].e);
        end
        u_urmz_host.set_mode(1'b0, 8'h00);
        // read side of shared addresses
        u_urmz_host.rd(ADDR_VEC, rd_val);
        chk(rd_val, 8'hc3);
        u_urmz_host.rd(ADDR_STAT, rd_val);
        chk(rd_val, 8'h0c);
        u_urmz_host.rd(ADDR_CMD, rd_val);
        chk(rd_val, 8'h00);
        u_urmz_host.rd(ADDR_CTHI, rd_val);
        chk(rd_val, 8'hbe);
        u_urmz_host.rd(ADDR_CTLO, rd_val);
        chk(rd_val, 8'h7d);
        // every fill code at both depths, one short then at the level
        for (int dp = 0; dp < 2; dp++) begin
            for (int c = 0; c < 4; c++) begin
                lvl = (dp == 1) ? lv16[c] : lv8[c];
                u_urmz_host.set_mode(1'b0, {1'b0, c[1], 2'b00, dp[0], 3'h0});
                u_urmz_host.set_mode(1'b1, {1'b0, c[0], 6'h00});
                for (int i = 1; i <= lvl; i++) begin
                    chk(8'(rx_request), 8'h00);
                    push(8'(i));
                end
                chk(8'(rx_request), 8'h01);
                for (int i = 1; i <= lvl; i++) begin
                    u_urmz_host.rd(ADDR_FIFO, rd_val);
                    chk(rd_val, 8'(i));
                end
                chk(8'(rx_request), 8'h00);
            end
        end
        // watchdog: one held character, level code needs eight
        u_urmz_host.set_mode(1'b0, 8'hc0);
        u_urmz_host.set_mode(1'b1, 8'h40);
        push(8'h9e);
        tick(63);
        chk(8'(rx_request), 8'h00);
        tick(1);
        chk(8'(rx_request), 8'h01);
        u_urmz_host.set_mode(1'b0, 8'h40);
        chk(8'(rx_request), 8'h00);
        tick(64);
        chk(8'(rx_request), 8'h00);
        u_urmz_host.rd(ADDR_FIFO, rd_val);
        chk(rd_val, 8'h9e);
        // tx queue at both depths, level code 01; a write when full is lost
        for (int dp = 0; dp < 2; dp++) begin
            lvl = (dp == 1) ? 16 : 8;
            u_urmz_host.set_mode(1'b0, {4'h1, dp[0], 3'h0});
            for (int i = 0; i <= lvl; i++) begin
                chk(8'(tx_request), 8'(lvl - i >= lvl / 2));
                u_urmz_host.wr(ADDR_FIFO, 8'(i + 8'ha0));
            end
            u_urmz_host.rd(ADDR_STAT, rd_val);
            chk(rd_val, 8'h00);
            // the transmitter takes one byte at every edge
            tx_take = 1'b1;
            for (int i = 0; i < lvl; i++) begin
                chk(tx_data, 8'(i + 8'ha0));
                @(posedge sys_clk);
                #1;
            end
            tx_take = 1'b0;
            chk(8'(tx_valid), 8'h00);
        end
        // rx overrun at depth eight; an error reset command clears it
        u_urmz_host.set_mode(1'b0, 8'h00);
        for (int i = 1; i <= 9; i++) begin
            push(8'(i));
        end
        u_urmz_host.rd(ADDR_STAT, rd_val);
        chk(rd_val, 8'h1f);
        k = n_cmd;
        u_urmz_host.wr(ADDR_CMD, 8'h47);
        chk(8'(n_cmd - k), 8'h01);
        chk(last_cmd, 8'h47);
        u_urmz_host.rd(ADDR_STAT, rd_val);
        chk(rd_val, 8'h0f);
        // counter strobes on reads of e and f; enable for two cycles
        k = n_oe;
        u_urmz_host.rd(ADDR_START, rd_val);
        chk(8'(n_oe - k), 8'h02);
        chk(rd_val, 8'h00);
        u_urmz_host.rd(ADDR_STOP, rd_val);
        chk({n_start[3:0], n_stop[3:0]}, 8'h11);
        // reset in mid-run: queues and registers clear, pointer at one
        reset_n = 1'b0;
        @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        chk({5'h00, tx_request, tx_valid, rx_request}, 8'h04);
        chk(data_out, 8'h00);
        u_urmz_host.wr(ADDR_MODE, 8'h5c);
        chk(mode_one, 8'h5c);
        chk(mode_zero, 8'h00);
        close_out();
    end
endmodule // test_uart_register_map_mode_zero
